// File: core/bpc_apb_regs.v
// APB register file holding the controller's orders and results
`include "bpc_consts.vh"
module bpc_apb_regs (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg go_q,
  output reg [3:0] op_q,
  output reg [23:0] addr_q,
  output reg [15:0] wdata_q,
  output reg [63:0] pwd_q,
  input wire busy,
  input wire bad,
  input wire [15:0] rdata
);
  wire acc = psel && penable && ce;
  wire wr = acc && pwrite && !pready;
  wire known = paddr == `BPC_REG_CMD || paddr == `BPC_REG_ADDR ||
    paddr == `BPC_REG_WDATA || paddr == `BPC_REG_STATUS ||
    paddr == `BPC_REG_RDATA || paddr == `BPC_REG_PWD01 || paddr == `BPC_REG_PWD23;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      go_q <= 1'b0;
      op_q <= 4'h0;
      addr_q <= 24'h0;
      wdata_q <= 16'h0;
      pwd_q <= 64'h0;
    end else if (ce) begin
      go_q <= 1'b0;
      pready <= acc && !pready;
      pslverr <= acc && !pready && !known;
      if (wr) begin
        case (paddr)
          `BPC_REG_CMD: begin
            op_q <= pwdata[3:0];
            go_q <= !busy;
          end
          `BPC_REG_ADDR: addr_q <= pwdata[23:0];
          `BPC_REG_WDATA: wdata_q <= pwdata[15:0];
          `BPC_REG_PWD01: pwd_q[31:0] <= pwdata;
          `BPC_REG_PWD23: pwd_q[63:32] <= pwdata;
          default: ;
        endcase
      end
      if (acc && !pwrite && !pready) begin
        case (paddr)
          `BPC_REG_CMD: prdata <= {28'h0, op_q};
          `BPC_REG_ADDR: prdata <= {8'h0, addr_q};
          `BPC_REG_WDATA: prdata <= {16'h0, wdata_q};
          `BPC_REG_STATUS: prdata <= {30'h0, bad, busy};
          `BPC_REG_RDATA: prdata <= {16'h0, rdata};
          `BPC_REG_PWD01: prdata <= pwd_q[31:0];
          `BPC_REG_PWD23: prdata <= pwd_q[63:32];
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule

// File: core/bpc_bus_cycle.v
// One asynchronous flash bus read or write cycle, paced by clock counts
`include "bpc_consts.vh"
module bpc_bus_cycle (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire start,
  input wire is_write,
  input wire [23:0] addr,
  input wire [15:0] wdata,
  input wire [15:0] dq_sync,
  output reg done,
  output reg [15:0] rdata,
  output reg [23:0] fl_addr,
  output reg [15:0] fl_dq_out,
  output reg fl_dq_oe,
  output reg fl_ce_n,
  output reg fl_oe_n,
  output reg fl_we_n
);
  localparam S_IDLE = 4'b0001;
  localparam S_SETUP = 4'b0010;
  localparam S_PULSE = 4'b0100;
  localparam S_HOLD = 4'b1000;
  reg [3:0] st_q;
  reg [3:0] cnt_q;
  reg wr_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0;
      fl_addr <= 24'h0;
      fl_dq_out <= 16'h0;
      fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
    end else if (ce) begin
      done <= 1'b0;
      case (st_q)
        S_IDLE: if (start) begin
          wr_q <= is_write;
          fl_addr <= addr;
          fl_dq_out <= wdata;
          fl_dq_oe <= is_write;
          fl_ce_n <= 1'b0;
          cnt_q <= 4'h0;
          st_q <= S_SETUP;
        end
        S_SETUP: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `BPC_T_SETUP - 1) begin
            cnt_q <= 4'h0;
            fl_we_n <= !wr_q;
            fl_oe_n <= wr_q;
            st_q <= S_PULSE;
          end
        end
        S_PULSE: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `BPC_T_PULSE - 1) begin
            // Sample before releasing output enable; input path is synchronised
            rdata <= dq_sync;
            cnt_q <= 4'h0;
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            st_q <= S_HOLD;
          end
        end
        S_HOLD: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `BPC_T_HOLD - 1) begin
            fl_ce_n <= 1'b1;
            fl_dq_oe <= 1'b0;
            done <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule

// File: core/bpc_consts.vh
// Constants for the block protection command controller
`ifndef BPC_CONSTS_VH
`define BPC_CONSTS_VH
`define BPC_ADDR_W 24
`define BPC_DATA_W 16
// APB register byte offsets
`define BPC_REG_CMD 12'h000
`define BPC_REG_ADDR 12'h004
`define BPC_REG_WDATA 12'h008
`define BPC_REG_STATUS 12'h00c
`define BPC_REG_RDATA 12'h010
`define BPC_REG_PWD01 12'h014
`define BPC_REG_PWD23 12'h018
// Command codes in the command register, bits 3:0
`define BPC_OP_ENTER_VOL 4'h1
`define BPC_OP_ENTER_NV 4'h2
`define BPC_OP_ENTER_LDB 4'h3
`define BPC_OP_ENTER_PWD 4'h4
`define BPC_OP_LOCK_BLOCK 4'h5
`define BPC_OP_FREE_BLOCK 4'h6
`define BPC_OP_ERASE_ALL 4'h7
`define BPC_OP_READ_BIT 4'h8
`define BPC_OP_PWD_PROG 4'h9
`define BPC_OP_PWD_READ 4'ha
`define BPC_OP_UNLOCK 4'hb
`define BPC_OP_EXIT 4'hc
// Status bit positions
`define BPC_ST_BUSY 0
`define BPC_ST_BAD 1
// Flash bus codes
`define BPC_A_555 24'h000555
`define BPC_A_2AA 24'h0002aa
`define BPC_D_AA 8'haa
`define BPC_D_55 8'h55
`define BPC_D_VOL 8'he0
`define BPC_D_NV 8'hc0
`define BPC_D_LDB 8'h50
`define BPC_D_PWD 8'h60
`define BPC_D_A0 8'ha0
`define BPC_D_80 8'h80
`define BPC_D_30 8'h30
`define BPC_D_90 8'h90
`define BPC_D_25 8'h25
`define BPC_D_03 8'h03
`define BPC_D_29 8'h29
// Unlock spacing in ns, and clock period in ns
`define BPC_UNLOCK_GAP_NS 1000
`define BPC_CLK_NS 10
`define BPC_UNLOCK_GAP_CYC ((`BPC_UNLOCK_GAP_NS + `BPC_CLK_NS - 1) / `BPC_CLK_NS)
// Bus cycle phase lengths in clocks
`define BPC_T_SETUP 2
`define BPC_T_PULSE 5
`define BPC_T_HOLD 2
`endif

// File: core/bpc_ctrl.v
// Host-side controller issuing flash block protection command sequences
//
// Local design decisions: the address map and register access over APB.
`include "bpc_consts.vh"
// What this block does
// - Volatile mode entry: 555/AA, 2AA/55, 555/E0
// - Block volatile lock: A0, then 00 at block
// - Block volatile free: A0, then 01 at block
// - Persistent mode entry ends with block/C0
// - Persistent block lock: A0, then 00 at block
// - Lock-down mode entry ends with 555/50
// - Lock-down program: A0 then 00
// - Password mode entry ends with 555/60
// - Password program: A0, word at WORD_SELECT_ADDRESS_BITS
// - Unlock: 25, 03, four words, 29
// - Unlock attempts spaced at least 1 us
// - Exit: 90 then 00 to read mode
module bpc_ctrl #(
  parameter UNLOCK_GAP = `BPC_UNLOCK_GAP_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire [23:0] fl_addr,
  output wire [15:0] fl_dq_out,
  output wire fl_dq_oe,
  input wire [15:0] fl_dq_in,
  output wire fl_ce_n,
  output wire fl_oe_n,
  output wire fl_we_n
);
  localparam S_IDLE = 4'b0001;
  localparam S_RUN = 4'b0010;
  localparam S_WAIT = 4'b0100;
  localparam S_NEXT = 4'b1000;

  ////////////////////////////////////////////////////////////////////////////
  // Command sequence step table: {is_write, address, data}
  function [40:0] step;
    input [3:0] op;
    input [2:0] idx;
    input [23:0] a;
    input [15:0] d;
    input [63:0] pw;
    reg [23:0] w555;
    reg [23:0] w2aa;
    begin
      w555 = `BPC_A_555;
      w2aa = `BPC_A_2AA;
      step = 41'h0;
      case (op)
        `BPC_OP_ENTER_VOL, `BPC_OP_ENTER_LDB, `BPC_OP_ENTER_PWD, `BPC_OP_ENTER_NV:
          case (idx)
            3'd0: step = {1'b1, w555, 8'h00, `BPC_D_AA};
            3'd1: step = {1'b1, w2aa, 8'h00, `BPC_D_55};
            default: begin
              if (op == `BPC_OP_ENTER_VOL)
                step = {1'b1, w555, 8'h00, `BPC_D_VOL};
              else if (op == `BPC_OP_ENTER_NV)
                step = {1'b1, a, 8'h00, `BPC_D_NV};
              else if (op == `BPC_OP_ENTER_LDB)
                step = {1'b1, w555, 8'h00, `BPC_D_LDB};
              else
                step = {1'b1, w555, 8'h00, `BPC_D_PWD};
            end
          endcase
        `BPC_OP_LOCK_BLOCK:
          // Lock-down program shares this shape with address ignored
          step = idx == 3'd0 ? {1'b1, a, 8'h00, `BPC_D_A0} :
            {1'b1, a, 16'h0000};
        `BPC_OP_FREE_BLOCK:
          step = idx == 3'd0 ? {1'b1, a, 8'h00, `BPC_D_A0} :
            {1'b1, a, 16'h0001};
        `BPC_OP_ERASE_ALL:
          step = idx == 3'd0 ? {1'b1, a, 8'h00, `BPC_D_80} :
            {1'b1, 24'h000000, 8'h00, `BPC_D_30};
        `BPC_OP_READ_BIT:
          step = {1'b0, a, 16'h0000};
        `BPC_OP_PWD_PROG:
          step = idx == 3'd0 ? {1'b1, a, 8'h00, `BPC_D_A0} :
            {1'b1, 22'h0, a[1:0], d};
        `BPC_OP_PWD_READ:
          step = {1'b0, 22'h0, idx[1:0], 16'h0000};
        `BPC_OP_UNLOCK:
          case (idx)
            3'd0: step = {1'b1, 24'h0, 8'h00, `BPC_D_25};
            3'd1: step = {1'b1, 24'h0, 8'h00, `BPC_D_03};
            3'd2: step = {1'b1, 24'h0, pw[15:0]};
            3'd3: step = {1'b1, 24'h1, pw[31:16]};
            3'd4: step = {1'b1, 24'h2, pw[47:32]};
            3'd5: step = {1'b1, 24'h3, pw[63:48]};
            default: step = {1'b1, 24'h0, 8'h00, `BPC_D_29};
          endcase
        default:
          step = idx == 3'd0 ? {1'b1, a, 8'h00, `BPC_D_90} :
            {1'b1, a, 16'h0000};
      endcase
    end
  endfunction

  function [2:0] last_idx;
    input [3:0] op;
    begin
      case (op)
        `BPC_OP_ENTER_VOL, `BPC_OP_ENTER_NV, `BPC_OP_ENTER_LDB,
        `BPC_OP_ENTER_PWD: last_idx = 3'd2;
        `BPC_OP_READ_BIT: last_idx = 3'd0;
        `BPC_OP_PWD_READ: last_idx = 3'd3;
        `BPC_OP_UNLOCK: last_idx = 3'd6;
        default: last_idx = 3'd1;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and pin synchroniser
  wire go;
  wire [3:0] op;
  wire [23:0] addr;
  wire [15:0] wdata;
  wire [63:0] pwd;
  wire cyc_done;
  wire [15:0] cyc_rdata;
  reg [15:0] dq_s1_q;
  reg [15:0] dq_s2_q;
  reg [3:0] st_q;
  reg [3:0] op_q;
  reg [2:0] idx_q;
  reg start_q;
  reg bad_q;
  reg [15:0] rd_q;
  reg [15:0] gap_q;
  wire [40:0] cur = step(op_q, idx_q, addr, wdata, pwd);
  wire busy = st_q != S_IDLE;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1_q <= 16'h0;
      dq_s2_q <= 16'h0;
    end else if (ce) begin
      dq_s1_q <= fl_dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  bpc_apb_regs u_regs (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .go_q(go),
    .op_q(op),
    .addr_q(addr),
    .wdata_q(wdata),
    .pwd_q(pwd),
    .busy(busy),
    .bad(bad_q),
    .rdata(rd_q)
  );

  bpc_bus_cycle u_cyc (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(start_q),
    .is_write(cur[40]),
    .addr(cur[39:16]),
    .wdata(cur[15:0]),
    .dq_sync(dq_s2_q),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe),
    .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      op_q <= 4'h0;
      idx_q <= 3'd0;
      start_q <= 1'b0;
      bad_q <= 1'b0;
      rd_q <= 16'h0;
      gap_q <= 16'h0;
    end else if (ce) begin
      start_q <= 1'b0;
      if (gap_q != 16'h0)
        gap_q <= gap_q - 16'h1;
      case (st_q)
        S_IDLE: if (go) begin
          if (op < `BPC_OP_ENTER_VOL || op > `BPC_OP_EXIT) begin
            bad_q <= 1'b1;
          end else if (op == `BPC_OP_UNLOCK && gap_q != 16'h0) begin
            bad_q <= 1'b1;
          end else begin
            bad_q <= 1'b0;
            op_q <= op;
            idx_q <= 3'd0;
            start_q <= 1'b1;
            st_q <= S_WAIT;
          end
        end
        S_WAIT: if (cyc_done) begin
          // Only DQ0 matters for bit reads; password reads keep all 16 bits
          if (!cur[40])
            rd_q <= op_q == `BPC_OP_READ_BIT ? {15'h0, cyc_rdata[0]} : cyc_rdata;
          if (idx_q == last_idx(op_q)) begin
            st_q <= S_IDLE;
            // Spacing counts from the end of the last write; covers settle too
            if (op_q == `BPC_OP_UNLOCK)
              gap_q <= UNLOCK_GAP[15:0];
          end else begin
            st_q <= S_NEXT;
          end
        end
        S_NEXT: begin
          idx_q <= idx_q + 3'd1;
          st_q <= S_RUN;
        end
        S_RUN: begin
          start_q <= 1'b1;
          st_q <= S_WAIT;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule

// File: verification/bpc_ctrl_properties.sv
// Checker of bus answer and flash pin timing at the controller ports
module bpc_ctrl_props #(
  parameter UNLOCK_GAP = 100
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [23:0] fl_addr,
  input wire [15:0] fl_dq_out,
  input wire fl_dq_oe,
  input wire fl_ce_n,
  input wire fl_oe_n,
  input wire fl_we_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  a_one_wait: assert property ($rose(penable) && psel && ce |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  a_we_width: assert property ($fell(fl_we_n) |-> !fl_we_n [*5] ##1 fl_we_n)
    else $error("write pulse width");
  a_oe_width: assert property ($fell(fl_oe_n) |-> !fl_oe_n [*5] ##1 fl_oe_n)
    else $error("read pulse width");
  a_we_setup: assert property ($fell(fl_we_n) |-> $past(fl_ce_n, 2) == 1'b0)
    else $error("write setup short");
  a_write_drv: assert property (!fl_we_n |-> fl_dq_oe && !fl_ce_n)
    else $error("write not driven");
  a_read_float: assert property (!fl_oe_n |-> !fl_dq_oe && !fl_ce_n && fl_we_n)
    else $error("read contention");
  a_hold_stable: assert property (!fl_we_n |-> $stable(fl_addr) && $stable(fl_dq_out))
    else $error("write lines moved");
  a_idle_quiet: assert property (fl_ce_n |-> fl_we_n && fl_oe_n && !fl_dq_oe)
    else $error("strobe while idle");
  a_ce_freeze: assert property (!ce |=> $stable(pready) && $stable(pslverr) && $stable(fl_ce_n))
    else $error("state moved while frozen");
  c_write: cover property (!fl_we_n);
  c_read: cover property (!fl_oe_n);
  c_err: cover property (pslverr);
endmodule
bind bpc_ctrl bpc_ctrl_props #(.UNLOCK_GAP(UNLOCK_GAP)) i_props (.clk, .rst_n, .ce, .psel,
  .penable, .pready, .pslverr, .fl_addr, .fl_dq_out, .fl_dq_oe, .fl_ce_n, .fl_oe_n, .fl_we_n);

// File: verification/bpc_flash_model.sv
// Behavioural flash device keeping the protection command sets
module bpc_flash_model (
  input wire logic [23:0] a,
  input wire logic [15:0] d,
  output wire logic [15:0] q,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [255:0] vol = '1;
  logic [255:0] nvb = '1;
  logic [15:0] pw [4] = '{4{16'hffff}};
  logic ldb = 1'b1;
  logic ok;
  logic [15:0] rv;
  int md = 0;
  int st = 0;
  wire [7:0] c = d[7:0];
  wire [7:0] b = a[23:16];
  wire at555 = a[11:0] == 12'h555;
  // A cleared persistent bit locks the block whatever its volatile bit says
  wire prot = !(vol[b] && nvb[b]);
  ////////////////////////////////////////
  // Unmatched writes fall through and leave mode and bits alone
  always @(posedge we_n) if (!ce_n) begin
    if (st == 5) begin
      case (md)
        1: vol[b] = c[0];
        2: if (c == 8'h00) nvb[b] = 1'b0;
        3: ldb = 1'b0;
        4: pw[a[1:0]] = d;
      endcase
      st = 0;
    end else if (st >= 10) begin
      // Only the four password words are compared; the closing write is not a word
      if (st > 10 && st < 15) ok = ok & (d == pw[st - 11]);
      st++;
      if (st == 16) begin
        if (ok && c == 8'h29) fork #1000 ldb = 1'b1; join_none
        st = 0;
      end
    end else if (c == 8'h90) st = 9;
    else if (st == 9) begin
      if (c == 8'h00) md = 0;
      st = 0;
    end else if (st == 1) st = (a[11:0] == 12'h2aa && c == 8'h55) ? 2 : 0;
    else if (st == 2) begin
      if (c == 8'he0 && at555) md = 1;
      if (c == 8'hc0) md = 2;
      if (c == 8'h50 && at555) md = 3;
      if (c == 8'h60 && at555) md = 4;
      st = 0;
    end else if (st == 6) begin
      if (c == 8'h30 && a == 24'h0 && ldb) nvb = '1;
      st = 0;
    end else if (md == 0) st = (at555 && c == 8'haa) ? 1 : 0;
    else if (c == 8'ha0) st = 5;
    else if (c == 8'h80 && md == 2) st = 6;
    else if (c == 8'h25 && md == 4) begin
      st = 10;
      ok = 1'b1;
    end
  end
  always @* case (md)
    1: rv = {15'h0, vol[b]};
    2: rv = {15'h0, nvb[b]};
    3: rv = {15'h0, ldb};
    4: rv = pw[a[1:0]];
    default: rv = 16'h0000;
  endcase
  // Released bus shows the inverse so a stale sample cannot pass
  assign q = (!ce_n && !oe_n) ? rv : ~rv;
endmodule

// File: verification/test_bpc_ctrl.sv
// Self-checking bench for the protection command controller
`include "bpc_consts.vh"
module test_bpc_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GAP = `BPC_UNLOCK_GAP_CYC;
  logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, er;
  logic fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] fl_addr;
  logic [15:0] fl_dq_out, mq, fl_dq_in;
  logic [23:0] wa [16];
  logic [15:0] wd [16];
  int nw, miscompares, n_tests;
  assign fl_dq_in = fl_dq_oe ? fl_dq_out : mq;
  bpc_ctrl #(.UNLOCK_GAP(GAP)) i_dut (.clk, .rst_n, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .fl_addr, .fl_dq_out, .fl_dq_oe, .fl_dq_in,
    .fl_ce_n, .fl_oe_n, .fl_we_n);
  bpc_flash_model i_flash (.a(fl_addr), .d(fl_dq_out), .q(mq), .ce_n(fl_ce_n),
    .oe_n(fl_oe_n), .we_n(fl_we_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge fl_we_n) if (rst_n && !fl_ce_n && nw < 16) begin
    wa[nw] = fl_addr;
    wd[nw] = fl_dq_out;
    nw++;
  end
  ////////////////////////////////////////
  task automatic summarize;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic die;
    chk(0, 1);
    summarize;
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wdt);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wdt;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) die;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic [3:0] c, input logic [23:0] ad);
    int n;
    apb(1'b1, `BPC_REG_ADDR, ad);
    nw = 0;
    apb(1'b1, `BPC_REG_CMD, c);
    n = 0;
    do begin
      apb(1'b0, `BPC_REG_STATUS, 0);
      n++;
    end while (rd[`BPC_ST_BUSY] !== 1'b0 && n < 100);
    if (n >= 100) die;
  endtask
  task automatic rb(input logic [23:0] ad, input logic [15:0] e);
    op(4'h8, ad);
    apb(1'b0, `BPC_REG_RDATA, 0);
    chk(rd, {16'h0, e});
  endtask
  task automatic cw(input int i, input logic [23:0] a, input logic [15:0] d);
    chk(wa[i], a);
    chk(wd[i], d);
  endtask
  ////////////////////////////////////////
  task automatic t_basic;
    chk({fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe}, 4'he);
    apb(1'b0, 12'h020, 0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // Freeze the block while a status read is in flight; the answer must only be late
    fork
      apb(1'b0, `BPC_REG_STATUS, 0);
      begin
        @(posedge clk);
        ce <= 1'b0;
        repeat (6) @(posedge clk);
        ce <= 1'b1;
      end
    join
    chk({31'h0, er}, 32'h0);
    chk(rd, 32'h0);
    op(4'hd, 0);
    chk({nw[3:0], rd[`BPC_ST_BAD]}, 5'h01);
    $display("test basic done");
  endtask
  task automatic t_vol;
    op(4'h1, 0);
    cw(0, 24'h555, 16'haa);
    cw(1, 24'h2aa, 16'h55);
    cw(2, 24'h555, 16'he0);
    op(4'h5, 24'h050000);
    cw(1, 24'h050000, 16'h00);
    rb(24'h050000, 16'h0);
    rb(24'h060000, 16'h1);
    op(4'h6, 24'h050000);
    cw(1, 24'h050000, 16'h01);
    rb(24'h050000, 16'h1);
    op(4'hc, 0);
    cw(0, 0, 16'h90);
    cw(1, 0, 16'h00);
    $display("test volatile done");
  endtask
  task automatic t_nv;
    op(4'h2, 24'h070000);
    cw(2, 24'h070000, 16'hc0);
    op(4'h5, 24'h070000);
    rb(24'h070000, 16'h0);
    chk({31'h0, i_flash.prot}, 32'h1);
    op(4'h7, 0);
    cw(0, 0, 16'h80);
    cw(1, 0, 16'h30);
    rb(24'h070000, 16'h1);
    op(4'h5, 24'h070000);
    op(4'hc, 0);
    op(4'h3, 0);
    cw(2, 24'h555, 16'h50);
    rb(0, 16'h1);
    op(4'h5, 0);
    rb(0, 16'h0);
    op(4'hc, 0);
    op(4'h2, 24'h070000);
    op(4'h7, 0);
    rb(24'h070000, 16'h0);
    op(4'hc, 0);
    $display("test persistent done");
  endtask
  task automatic t_pwd;
    int i;
    op(4'h4, 0);
    cw(2, 24'h555, 16'h60);
    op(4'ha, 0);
    apb(1'b0, `BPC_REG_RDATA, 0);
    chk(rd, 32'hffff);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, `BPC_REG_WDATA, 32'h1230 + i);
      op(4'h9, i);
      cw(1, i, 16'h1230 + i);
    end
    op(4'ha, 0);
    apb(1'b0, `BPC_REG_RDATA, 0);
    chk(rd, 32'h1233);
    apb(1'b1, `BPC_REG_PWD01, 32'h12311230);
    apb(1'b1, `BPC_REG_PWD23, 32'h12331232);
    op(4'hb, 0);
    chk(nw, 7);
    cw(1, 0, 16'h03);
    cw(4, 2, 16'h1232);
    cw(6, 0, 16'h29);
    // Retry lands well inside the gap, so it must be refused
    op(4'hb, 0);
    chk({nw[3:0], rd[`BPC_ST_BAD]}, 5'h01);
    op(4'hc, 0);
    repeat (120) @(posedge clk);
    op(4'hb, 0);
    chk({nw[3:0], rd[`BPC_ST_BAD]}, 5'he);
    op(4'h3, 0);
    rb(0, 16'h1);
    $display("test password done");
  endtask
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_basic;
    t_vol;
    t_nv;
    t_pwd;
    summarize;
  end
endmodule
